// >>> hdl/poll_engine_pkg.sv
// Constants, carriers and state encodings for the multipoint auto-poll engine.
// Assumes a byte-wide cycle-steal storage port and a byte-level half-duplex line port.
package poll_engine_pkg;

  // Core clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CS_TIMEOUT_NS = 10000;
  localparam int CS_TIMEOUT_CYC = CS_TIMEOUT_NS / CLK_PERIOD_NS; // Longest wait, rounded down
  localparam int RESP_TIMEOUT_US = 3000;

  // Parameter field layout, byte offsets from the starting current address
  localparam logic [8:0] OFS_TAR_HI = 9'h000;
  localparam logic [8:0] OFS_TAR_LO = 9'h001;
  localparam logic [8:0] OFS_SAR_HI = 9'h002;
  localparam logic [8:0] OFS_SAR_LO = 9'h003;
  localparam logic [8:0] OFS_MARK0 = 9'h004;
  localparam logic [8:0] OFS_MARK1 = 9'h005;
  localparam logic [8:0] OFS_COUNT = 9'h006;

  // Field values and sizes
  localparam logic [7:0] POLL_MARKER = 8'h8f;
  localparam logic [7:0] COUNT_ENDLESS = 8'hff;
  localparam logic [7:0] COUNT_NONE = 8'h00;
  localparam logic [6:0] MAX_TERMINALS = 7'h7f;
  localparam logic [8:0] BUF_BYTES = 9'h100;
  localparam logic [1:0] LAST_MISS = 2'h3; // Fourth unanswered poll

  // Line control characters
  localparam logic [7:0] CH_ENQ = 8'h2d;
  localparam logic [7:0] CH_EOT = 8'h37;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETB = 8'h26;
  localparam logic [7:0] CH_ETX = 8'h03;

  // Status byte 1 codes
  localparam logic [7:0] ST1_GOOD = 8'h02;
  localparam logic [7:0] ST1_OVERRUN = 8'h03;
  localparam logic [7:0] ST1_NO_DSR = 8'h10;
  localparam logic [7:0] ST1_FETCH_TO = 8'h22;
  localparam logic [7:0] ST1_STORE_TO = 8'h62;
  localparam logic [7:0] ST1_BAD_MARK = 8'h72;
  localparam logic [7:0] ST1_NO_END = 8'h7a;
  localparam logic [7:0] ST1_NO_ENQ = 8'h82;
  localparam logic [7:0] ST1_RX_TO = 8'ha2;
  localparam logic [7:0] ST1_ORDER = 8'hca;
  localparam logic [7:0] ST1_BAD_CTL = 8'hea;
  localparam logic [7:0] ST1_VRC = 8'hfa;

  // Status byte 2 codes
  localparam logic [7:0] ST2_NONE = 8'h00;
  localparam logic [7:0] ST2_RX_CHK = 8'h10;
  localparam logic [7:0] ST2_TX_CHK = 8'h20;
  localparam logic [7:0] ST2_BCC = 8'h40;
  localparam logic [7:0] ST2_TIMEOUT = 8'h80;

  typedef enum logic [1:0] {
    CMD_LOAD_CAR = 2'b00,
    CMD_START = 2'b01,
    CMD_STOP = 2'b10,
    CMD_NAK = 2'b11
  } cmd_op_t;

  typedef struct packed {
    logic valid;
    cmd_op_t op;
    logic [15:0] addr;
  } cmd_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cs_req_t;

  typedef struct packed {
    logic [7:0] seq;
    logic [7:0] st1;
    logic [7:0] st2;
  } status_t;

  typedef struct packed {
    logic valid;
    logic bcc_bad;
    logic vrc_bad;
    logic [7:0] data;
  } rx_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_POLL_TX = 3'b011,
    ST_POLL_WAIT = 3'b010,
    ST_MOVE = 3'b110,
    ST_WR_EOT = 3'b111,
    ST_POST = 3'b101,
    ST_WAIT_NAK = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_ADDR = 2'b01,
    LK_ENQ = 2'b11
  } link_state_t;

endpackage : poll_engine_pkg

// >>> hdl/multipoint_auto_poll_engine.sv
// Auto-poll engine: command decode, parameter fetch, poll loop, data move and status post.
// Assumes storage answers cycle-steal requests with a one-cycle ack on clk_in and that the
// line partner delivers and accepts whole bytes on link_clk_in.

// Line-side end: sends a poll (address then ENQ) and forwards received bytes to the core.
module poll_link_side (
  input wire logic link_clk_in,
  input wire logic sys_rst_in,
  input wire logic poll_tgl_in,
  input wire logic [7:0] poll_addr_in,
  input wire logic tx_ready_in,
  input wire poll_engine_pkg::rx_t rx_in,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  output logic rx_tgl_out,
  output poll_engine_pkg::rx_t rx_hold_out
);

  typedef struct packed {
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    poll_engine_pkg::link_state_t ph;
    logic [7:0] tx_byte;
    logic rx_tgl;
    poll_engine_pkg::rx_t rx_hold;
  } link_t;

  link_t q, n;

  // Poll request arrives as a toggle; address is stable in the core until the next poll
  always_comb begin
    n = q;
    n.tg_s1 = poll_tgl_in;
    n.tg_s2 = q.tg_s1;
    n.tg_s3 = q.tg_s2;
    unique case (q.ph)
      poll_engine_pkg::LK_IDLE: begin
        if (q.tg_s2 != q.tg_s3) begin
          n.tx_byte = poll_addr_in;
          n.ph = poll_engine_pkg::LK_ADDR;
        end
      end
      poll_engine_pkg::LK_ADDR: begin
        if (tx_ready_in) begin
          n.tx_byte = poll_engine_pkg::CH_ENQ;
          n.ph = poll_engine_pkg::LK_ENQ;
        end
      end
      poll_engine_pkg::LK_ENQ: begin
        if (tx_ready_in) begin
          n.ph = poll_engine_pkg::LK_IDLE;
        end
      end
      default: begin
        n.ph = poll_engine_pkg::LK_IDLE;
      end
    endcase
    // Each received byte is parked and announced by a toggle; bytes may arrive on back-to-back link clocks
    if (rx_in.valid) begin
      n.rx_hold = rx_in;
      n.rx_tgl = ~q.rx_tgl;
    end
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tx_valid_out = (q.ph != poll_engine_pkg::LK_IDLE);
  assign tx_data_out = q.tx_byte;
  assign rx_tgl_out = q.rx_tgl;
  assign rx_hold_out = q.rx_hold;

endmodule : poll_link_side

module multipoint_auto_poll_engine #(
  parameter int unsigned RESP_TIMEOUT_CYC = poll_engine_pkg::RESP_TIMEOUT_US * 1000 / poll_engine_pkg::CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire poll_engine_pkg::cmd_t cmd_in,
  input wire logic dsr_in,
  input wire logic cs_ack_in,
  input wire logic [7:0] cs_rdata_in,
  input wire logic tx_ready_in,
  input wire poll_engine_pkg::rx_t rx_in,
  output poll_engine_pkg::cs_req_t cs_req_out,
  output poll_engine_pkg::status_t status_out,
  output logic operation_end_interrupt_out,
  output logic reject_out,
  output logic busy_out,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out
);

  typedef struct packed {
    poll_engine_pkg::state_t st;
    logic [15:0] current_address_pointer;
    logic [15:0] transition_address_pointer;
    logic [15:0] stop_address_pointer;
    logic car_loaded;
    logic [8:0] fidx;
    logic [7:0] count;
    logic [7:0] pass;
    logic [6:0] tidx;
    logic [6:0] tcnt;
    logic [1:0] miss;
    logic [8:0] blen;
    logic [8:0] bidx;
    logic in_text;
    logic [19:0] tmr;
    logic [11:0] cstmr;
    poll_engine_pkg::cs_req_t cs;
    poll_engine_pkg::status_t stat;
    logic [1:0] pidx;
    logic irq;
    logic rej;
    logic nak_ok;
    logic poll_tgl;
    logic [7:0] poll_addr;
    logic dsr_s1;
    logic dsr_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
  } core_t;

  core_t q, n;
  logic [7:0] list_mem [0:126];
  logic [7:0] buf_mem [0:255];
  logic list_we, buf_we;
  logic [6:0] list_wa;
  logic [7:0] list_wd, buf_wd, buf_rd;
  logic [7:0] buf_wa;
  logic rx_tgl;
  poll_engine_pkg::rx_t rx_hold;

  function automatic poll_engine_pkg::cs_req_t cs_issue(input logic wr, input logic [15:0] a, input logic [7:0] d);
    cs_issue.req = 1'b1;
    cs_issue.write = wr;
    cs_issue.addr = a;
    cs_issue.wdata = d;
  endfunction : cs_issue

  // Enter the three-byte status post at the current address
  function automatic core_t begin_post(input core_t s, input logic [7:0] st1, input logic [7:0] st2);
    begin_post = s;
    begin_post.stat.seq = {s.tidx, 1'b1};
    begin_post.stat.st1 = st1;
    begin_post.stat.st2 = st2;
    begin_post.pidx = 2'h0;
    begin_post.nak_ok = (st1 == poll_engine_pkg::ST1_OVERRUN);
    begin_post.st = poll_engine_pkg::ST_POST;
    begin_post.cs = cs_issue(1'b1, s.current_address_pointer, {s.tidx, 1'b1});
  endfunction : begin_post

  assign buf_rd = buf_mem[q.bidx[7:0]];

  // One pass over the whole engine; commands are checked after the state step so they win
  always_comb begin
    n = q;
    n.irq = 1'b0;
    n.rej = 1'b0;
    n.dsr_s1 = dsr_in;
    n.dsr_s2 = q.dsr_s1;
    n.rx_s1 = rx_tgl;
    n.rx_s2 = q.rx_s1;
    n.rx_s3 = q.rx_s2;
    list_we = 1'b0;
    list_wa = q.tcnt;
    list_wd = cs_rdata_in;
    buf_we = 1'b0;
    buf_wa = q.blen[7:0];
    buf_wd = rx_hold.data;
    // Cycle-steal watchdog: a request never answered is dropped, and reported unless it is a status post write
    if (q.cs.req) begin
      n.cstmr = q.cstmr + 12'h001;
      if (cs_ack_in || q.cstmr == 12'(poll_engine_pkg::CS_TIMEOUT_CYC - 1)) begin
        n.cs.req = 1'b0;
        n.cstmr = 12'h000;
      end
    end
    unique case (q.st)
      poll_engine_pkg::ST_IDLE, poll_engine_pkg::ST_WAIT_NAK: begin
      end
      poll_engine_pkg::ST_FETCH: begin
        if (q.cs.req && cs_ack_in) begin
          n.current_address_pointer = q.current_address_pointer + 16'h0001;
          n.fidx = q.fidx + 9'h001;
          n.cs = cs_issue(1'b0, n.current_address_pointer, 8'h00);
          unique case (q.fidx)
            poll_engine_pkg::OFS_TAR_HI: n.transition_address_pointer[15:8] = cs_rdata_in;
            poll_engine_pkg::OFS_TAR_LO: n.transition_address_pointer[7:0] = cs_rdata_in;
            poll_engine_pkg::OFS_SAR_HI: n.stop_address_pointer[15:8] = cs_rdata_in;
            poll_engine_pkg::OFS_SAR_LO: n.stop_address_pointer[7:0] = cs_rdata_in;
            poll_engine_pkg::OFS_MARK0: begin
              // Only the auto-poll form of the field is handled here
              if (cs_rdata_in != poll_engine_pkg::POLL_MARKER) begin
                n = begin_post(n, poll_engine_pkg::ST1_BAD_CTL, poll_engine_pkg::ST2_NONE);
              end
            end
            poll_engine_pkg::OFS_MARK1: begin
              if (cs_rdata_in != poll_engine_pkg::POLL_MARKER) begin
                n = begin_post(n, poll_engine_pkg::ST1_BAD_MARK, poll_engine_pkg::ST2_NONE);
              end
            end
            poll_engine_pkg::OFS_COUNT: begin
              n.count = cs_rdata_in;
              if (cs_rdata_in == poll_engine_pkg::COUNT_NONE) begin
                n = begin_post(n, poll_engine_pkg::ST1_BAD_CTL, poll_engine_pkg::ST2_NONE);
              end
            end
            default: begin
              if (cs_rdata_in == poll_engine_pkg::CH_ENQ) begin
                n.cs.req = 1'b0;
                n.tidx = 7'h00;
                n.pass = 8'h00;
                n.miss = 2'h0;
                n.st = poll_engine_pkg::ST_POLL_TX;
                if (q.tcnt == 7'h00) begin
                  n = begin_post(n, poll_engine_pkg::ST1_BAD_CTL, poll_engine_pkg::ST2_NONE);
                end
              end else if (q.fidx == poll_engine_pkg::BUF_BYTES - 9'h001) begin
                n = begin_post(n, poll_engine_pkg::ST1_NO_ENQ, poll_engine_pkg::ST2_NONE);
              end else if (q.tcnt == poll_engine_pkg::MAX_TERMINALS) begin
                n = begin_post(n, poll_engine_pkg::ST1_BAD_CTL, poll_engine_pkg::ST2_NONE);
              end else begin
                list_we = 1'b1;
                n.tcnt = q.tcnt + 7'h01;
              end
            end
          endcase
        end else if (q.cs.req && !n.cs.req) begin
          n = begin_post(n, poll_engine_pkg::ST1_FETCH_TO, poll_engine_pkg::ST2_TX_CHK);
        end
      end
      poll_engine_pkg::ST_POLL_TX: begin
        n.poll_addr = list_mem[q.tidx];
        n.poll_tgl = ~q.poll_tgl;
        n.tmr = 20'h00000;
        n.in_text = 1'b0;
        n.st = poll_engine_pkg::ST_POLL_WAIT;
      end
      poll_engine_pkg::ST_POLL_WAIT: begin
        n.tmr = q.tmr + 20'h00001;
        if (q.rx_s2 != q.rx_s3) begin
          n.tmr = 20'h00000;
          if (!q.in_text) begin
            if (rx_hold.data == poll_engine_pkg::CH_EOT) begin
              // Nothing to send: move on down the list
              n.miss = 2'h0;
              n.st = poll_engine_pkg::ST_POLL_TX;
              if (q.tidx == q.tcnt - 7'h01) begin
                n.tidx = 7'h00;
                n.pass = q.pass + 8'h01;
                if (q.count != poll_engine_pkg::COUNT_ENDLESS && q.pass + 8'h01 == q.count) begin
                  n.tidx = q.tidx;
                  n.st = poll_engine_pkg::ST_WR_EOT;
                  n.cs = cs_issue(1'b1, q.current_address_pointer, poll_engine_pkg::CH_EOT);
                end
              end else begin
                n.tidx = q.tidx + 7'h01;
              end
            end else if (rx_hold.data == poll_engine_pkg::CH_STX) begin
              n.in_text = 1'b1;
              n.blen = 9'h000;
            end
          end else if (rx_hold.data == poll_engine_pkg::CH_ETB || rx_hold.data == poll_engine_pkg::CH_ETX) begin
            if (rx_hold.bcc_bad) begin
              n = begin_post(n, rx_hold.vrc_bad ? poll_engine_pkg::ST1_VRC : poll_engine_pkg::ST1_GOOD,
                             poll_engine_pkg::ST2_BCC);
            end else begin
              n.bidx = 9'h000;
              n.st = poll_engine_pkg::ST_MOVE;
            end
          end else if (q.blen == poll_engine_pkg::BUF_BYTES) begin
            n = begin_post(n, poll_engine_pkg::ST1_NO_END, poll_engine_pkg::ST2_NONE);
          end else begin
            buf_we = 1'b1;
            n.blen = q.blen + 9'h001;
          end
        end else if (q.tmr == 20'(RESP_TIMEOUT_CYC - 1)) begin
          if (q.miss == poll_engine_pkg::LAST_MISS) begin
            n = begin_post(n, poll_engine_pkg::ST1_RX_TO, poll_engine_pkg::ST2_TIMEOUT);
          end else begin
            n.miss = q.miss + 2'h1;
            n.st = poll_engine_pkg::ST_POLL_TX;
          end
        end
      end
      poll_engine_pkg::ST_MOVE: begin
        // One byte per request; an idle cycle sits between requests
        if (q.cs.req && cs_ack_in) begin
          n.current_address_pointer = q.current_address_pointer + 16'h0001;
          n.bidx = q.bidx + 9'h001;
        end else if (q.cs.req && !n.cs.req) begin
          n = begin_post(n, poll_engine_pkg::ST1_STORE_TO, poll_engine_pkg::ST2_RX_CHK);
        end else if (!q.cs.req) begin
          if (q.bidx == q.blen) begin
            n = begin_post(n, poll_engine_pkg::ST1_GOOD, poll_engine_pkg::ST2_NONE);
          end else if (q.current_address_pointer == q.stop_address_pointer) begin
            n = begin_post(n, poll_engine_pkg::ST1_OVERRUN, poll_engine_pkg::ST2_NONE);
          end else begin
            n.cs = cs_issue(1'b1, q.current_address_pointer, buf_rd);
          end
        end
      end
      poll_engine_pkg::ST_WR_EOT: begin
        if (q.cs.req && cs_ack_in) begin
          n.current_address_pointer = q.current_address_pointer + 16'h0001;
          n = begin_post(n, poll_engine_pkg::ST1_GOOD, poll_engine_pkg::ST2_NONE);
        end else if (q.cs.req && !n.cs.req) begin
          n = begin_post(n, poll_engine_pkg::ST1_STORE_TO, poll_engine_pkg::ST2_RX_CHK);
        end
      end
      poll_engine_pkg::ST_POST: begin
        // Sequence, then status 1, then status 2; a lost write still ends the operation
        if (q.cs.req && !n.cs.req) begin
          if (cs_ack_in) begin
            n.current_address_pointer = q.current_address_pointer + 16'h0001;
          end
          n.pidx = q.pidx + 2'h1;
          if (q.pidx == 2'h2) begin
            n.irq = 1'b1;
            n.st = q.nak_ok ? poll_engine_pkg::ST_WAIT_NAK : poll_engine_pkg::ST_IDLE;
          end else begin
            n.cs = cs_issue(1'b1, n.current_address_pointer, q.pidx == 2'h0 ? q.stat.st1 : q.stat.st2);
          end
        end
      end
    endcase
    // Host commands
    if (cmd_in.valid) begin
      unique case (cmd_in.op)
        poll_engine_pkg::CMD_LOAD_CAR: begin
          if (q.st != poll_engine_pkg::ST_IDLE && q.st != poll_engine_pkg::ST_WAIT_NAK) begin
            n.rej = 1'b1;
            n.stat.st1 = poll_engine_pkg::ST1_ORDER;
            n.stat.st2 = poll_engine_pkg::ST2_NONE;
          end else begin
            n.current_address_pointer = cmd_in.addr;
            n.car_loaded = 1'b1;
          end
        end
        poll_engine_pkg::CMD_START: begin
          if ((q.st != poll_engine_pkg::ST_IDLE && q.st != poll_engine_pkg::ST_WAIT_NAK) || !q.car_loaded) begin
            n.rej = 1'b1;
            n.stat.st1 = poll_engine_pkg::ST1_ORDER;
            n.stat.st2 = poll_engine_pkg::ST2_NONE;
          end else begin
            n.tidx = 7'h00;
            n.tcnt = 7'h00;
            n.nak_ok = 1'b0;
            if (!q.dsr_s2) begin
              n = begin_post(n, poll_engine_pkg::ST1_NO_DSR, poll_engine_pkg::ST2_NONE);
            end else begin
              n.fidx = 9'h000;
              n.st = poll_engine_pkg::ST_FETCH;
              n.cs = cs_issue(1'b0, q.current_address_pointer, 8'h00);
            end
          end
        end
        poll_engine_pkg::CMD_STOP: begin
          if (q.st == poll_engine_pkg::ST_POLL_TX || q.st == poll_engine_pkg::ST_POLL_WAIT) begin
            n = begin_post(q, poll_engine_pkg::ST1_GOOD, poll_engine_pkg::ST2_NONE);
            // Built from q, so pulses of the last cycle must not be carried over
            n.irq = 1'b0;
            n.rej = 1'b0;
            n.dsr_s1 = dsr_in;
            n.dsr_s2 = q.dsr_s1;
            n.rx_s1 = rx_tgl;
            n.rx_s2 = q.rx_s1;
            n.rx_s3 = q.rx_s2;
          end
        end
        poll_engine_pkg::CMD_NAK: begin
          // The NAK never reaches the line: the held block is stored again instead
          if (q.st == poll_engine_pkg::ST_WAIT_NAK) begin
            n.bidx = 9'h000;
            n.nak_ok = 1'b0;
            n.st = poll_engine_pkg::ST_MOVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Poll list and answer buffer hold no control state, so they take no reset
  always_ff @(posedge clk_in) begin
    if (list_we) begin
      list_mem[list_wa] <= list_wd;
    end
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  poll_link_side link_side (
    .link_clk_in(link_clk_in),
    .sys_rst_in(sys_rst_in),
    .poll_tgl_in(q.poll_tgl),
    .poll_addr_in(q.poll_addr),
    .tx_ready_in(tx_ready_in),
    .rx_in(rx_in),
    .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out),
    .rx_tgl_out(rx_tgl),
    .rx_hold_out(rx_hold)
  );

  assign cs_req_out = q.cs;
  assign status_out = q.stat;
  assign operation_end_interrupt_out = q.irq;
  assign reject_out = q.rej;
  assign busy_out = (q.st != poll_engine_pkg::ST_IDLE) && (q.st != poll_engine_pkg::ST_WAIT_NAK);

endmodule : multipoint_auto_poll_engine

// >>> bench/poll_engine_monitor.sv
// Concurrent checks on the auto-poll engine's top ports.
// Assumes the bind below reaches every engine instance.
module poll_engine_monitor (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire poll_engine_pkg::cmd_t cmd_in,
  input wire logic cs_ack_in,
  input wire poll_engine_pkg::cs_req_t cs_req_out,
  input wire poll_engine_pkg::status_t status_out,
  input wire logic operation_end_interrupt_out,
  input wire logic reject_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Command answers, fetch stepping, post framing and line bytes
  a_start_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cmd_in.valid && cmd_in.op == poll_engine_pkg::CMD_START |=> cs_req_out.req || reject_out)
    else $error("start left unanswered");
  a_fetch_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cs_req_out.req && !cs_req_out.write && cs_ack_in ##1 cs_req_out.req && !cs_req_out.write
    |-> cs_req_out.addr == $past(cs_req_out.addr) + 16'h0001)
    else $error("fetch address did not step by one");
  a_write_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cs_req_out.req && cs_req_out.write && cs_ack_in
    |=> !(cs_req_out.req && cs_req_out.write && cs_req_out.addr == $past(cs_req_out.addr)))
    else $error("write request held after ack");
  a_irq_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    operation_end_interrupt_out |-> $past(cs_ack_in && cs_req_out.req && cs_req_out.write))
    else $error("interrupt without a finished status write");
  a_irq_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    operation_end_interrupt_out |=> !operation_end_interrupt_out)
    else $error("interrupt longer than one cycle");
  a_reject_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reject_out |-> status_out.st1 == poll_engine_pkg::ST1_ORDER)
    else $error("refusal with wrong status code");
  a_seq_odd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    operation_end_interrupt_out |-> status_out.seq[0] && status_out.seq <= 8'hfd)
    else $error("sequence number out of range");
  a_marker_kept: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    tx_valid_out |-> tx_data_out != poll_engine_pkg::POLL_MARKER)
    else $error("marker byte sent on the line");
endmodule : poll_engine_monitor

bind multipoint_auto_poll_engine poll_engine_monitor u_mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .link_clk_in(link_clk_in), .cmd_in(cmd_in), .cs_ack_in(cs_ack_in), .cs_req_out(cs_req_out),
  .status_out(status_out), .operation_end_interrupt_out(operation_end_interrupt_out),
  .reject_out(reject_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out));

// >>> bench/line_partner.sv
// Polled terminals on the line: takes poll bytes, answers each ENQ in modes 1 and 2.
// Assumes byte transfers on link_clk_in; mode 0 silent, 1 EOT, 2 short text block.
module line_partner (
  input wire logic link_clk_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output poll_engine_pkg::rx_t rx_out,
  output int n_tx_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q [$];
  int gap;
  initial begin
    tx_ready_out = 1'b0;
    rx_out = '0;
    n_tx_out = 0;
    gap = 0;
  end
  // Ready toggles so the engine must hold each byte through a stall
  always @(posedge link_clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      n_tx_out = n_tx_out + 1;
      if (tx_data_in == poll_engine_pkg::CH_ENQ && mode_in == 2'h1) q = '{poll_engine_pkg::CH_EOT};
      if (tx_data_in == poll_engine_pkg::CH_ENQ && mode_in == 2'h2)
        q = '{poll_engine_pkg::CH_STX, 8'h11, 8'h22, poll_engine_pkg::CH_ETX};
    end
    #1;
    tx_ready_out = ~tx_ready_out;
    rx_out.valid = 1'b0;
    rx_out.data = ~rx_out.data; // Idle line never repeats the last byte
    gap = gap + 1;
    // Bytes spaced three link cycles apart, above the engine's minimum
    if (q.size() > 0 && gap > 2) begin
      rx_out.data = q.pop_front();
      rx_out.valid = 1'b1;
      gap = 0;
    end
  end
endmodule : line_partner

// >>> bench/multipoint_auto_poll_engine_tb_top.sv
// Self-checking bench: storage model, line partner and scenario tasks.
// Assumes the monitor is bound from its own file; field laid out at 16'h0010.
module multipoint_auto_poll_engine_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, link_clk_in, sys_rst_in, dsr_in, cs_ack_in, tx_ready_in, irq, reject_out, busy_out, tx_valid_out;
  logic [7:0] cs_rdata_in, tx_data_out, mem [0:511];
  logic [15:0] last_wa;
  logic [1:0] mode;
  poll_engine_pkg::cmd_t cmd_in;
  poll_engine_pkg::cs_req_t cs_req_out;
  poll_engine_pkg::status_t status_out;
  poll_engine_pkg::rx_t rx_in;
  int n_fail, checks, ntx, n_tx;
  multipoint_auto_poll_engine #(.RESP_TIMEOUT_CYC(400)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .link_clk_in(link_clk_in), .cmd_in(cmd_in), .dsr_in(dsr_in), .cs_ack_in(cs_ack_in),
    .cs_rdata_in(cs_rdata_in), .tx_ready_in(tx_ready_in), .rx_in(rx_in), .cs_req_out(cs_req_out),
    .status_out(status_out), .operation_end_interrupt_out(irq), .reject_out(reject_out),
    .busy_out(busy_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out));
  line_partner u_line (.link_clk_in(link_clk_in), .mode_in(mode), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in), .rx_out(rx_in), .n_tx_out(n_tx));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Link clock offset so its edges never line up with the core clock's rising edges
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #32 link_clk_in = ~link_clk_in;
  end
  // Storage acks every other cycle so fetches run at half speed
  always @(posedge clk_in) begin
    #1;
    cs_ack_in = cs_req_out.req && !cs_ack_in;
    if (cs_ack_in && cs_req_out.write) mem[cs_req_out.addr[8:0]] = cs_req_out.wdata;
    if (cs_ack_in && cs_req_out.write) last_wa = cs_req_out.addr;
    cs_rdata_in = cs_ack_in ? mem[cs_req_out.addr[8:0]] : ~cs_rdata_in;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic send(input poll_engine_pkg::cmd_op_t op, input logic [15:0] a);
    @(posedge clk_in);
    #1 cmd_in = '{1'b1, op, a};
    @(posedge clk_in);
    #1 cmd_in.valid = 1'b0;
  endtask : send
  // Lays out pointers, marker, count, list and ENQ, then loads and starts
  task automatic run(input logic [7:0] m1, input logic [7:0] cnt, input int nt, input logic [1:0] md);
    int i;
    mode = md;
    {mem[16], mem[17], mem[18], mem[19], mem[20], mem[21], mem[22]} = {32'h000001ff, 8'h8f, m1, cnt};
    for (i = 0; i < nt; i++) mem[23 + i] = 8'hc1 + i[7:0];
    mem[23 + nt] = poll_engine_pkg::CH_ENQ;
    ntx = n_tx;
    send(poll_engine_pkg::CMD_LOAD_CAR, 16'h0010);
    send(poll_engine_pkg::CMD_START, 16'h0000);
  endtask : run
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk_in) #1;
    if (irq !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_irq
  // Status bytes sit just below the final current address
  task automatic post(input logic [7:0] s1, input logic [7:0] s2);
    cmp(mem[last_wa[8:0]], s2);
    cmp(mem[last_wa[8:0] - 9'h001], s1);
    cmp(status_out.st1, s1);
  endtask : post
  task automatic t_order;
    // The refusal pulse stands only in the cycle right after the command edge
    send(poll_engine_pkg::CMD_START, 16'h0000);
    cmp({7'h00, reject_out}, 8'h01);
    cmp({7'h00, busy_out}, 8'h00);
    cmp(status_out.st1, poll_engine_pkg::ST1_ORDER);
  endtask : t_order
  task automatic t_passes;
    run(8'h8f, 8'h02, 2, 2'h1);
    wait_irq(20000);
    cmp(mem[26], poll_engine_pkg::CH_EOT);
    cmp(mem[last_wa[8:0] - 9'h002], 8'h03);
    post(poll_engine_pkg::ST1_GOOD, poll_engine_pkg::ST2_NONE);
    cmp(8'(n_tx - ntx), 8'h08);
  endtask : t_passes
  task automatic t_bad_field;
    run(8'h00, 8'h01, 1, 2'h1);
    wait_irq(2000);
    post(poll_engine_pkg::ST1_BAD_MARK, poll_engine_pkg::ST2_NONE);
    run(8'h8f, 8'h00, 1, 2'h1);
    wait_irq(2000);
    post(poll_engine_pkg::ST1_BAD_CTL, poll_engine_pkg::ST2_NONE);
  endtask : t_bad_field
  // Endless polling of a silent terminal, with a refused load on the way
  task automatic t_silent;
    run(8'h8f, poll_engine_pkg::COUNT_ENDLESS, 1, 2'h0);
    send(poll_engine_pkg::CMD_LOAD_CAR, 16'h0010);
    cmp({7'h00, reject_out}, 8'h01);
    cmp({7'h00, busy_out}, 8'h01);
    wait_irq(20000);
    cmp(mem[last_wa[8:0] - 9'h002], 8'h01);
    post(poll_engine_pkg::ST1_RX_TO, poll_engine_pkg::ST2_TIMEOUT);
    cmp(8'(n_tx - ntx), 8'h08);
  endtask : t_silent
  task automatic t_data;
    run(8'h8f, 8'h01, 1, 2'h2);
    wait_irq(20000);
    cmp(mem[25], 8'h11);
    cmp(mem[26], 8'h22);
    post(poll_engine_pkg::ST1_GOOD, poll_engine_pkg::ST2_NONE);
  endtask : t_data
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    {sys_rst_in, dsr_in, cs_ack_in, cs_rdata_in, last_wa, mode, cmd_in} = {2'b11, 1'b0, 8'h00, 16'h0000, 2'h0, 19'h0};
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    t_order();
    t_passes();
    t_bad_field();
    t_silent();
    t_data();
    end_of_test();
  end
endmodule : multipoint_auto_poll_engine_tb_top
